// file: tpg_pkg.sv
// Package with register map, field positions, reset values and state types of the pulse generator.
package tpg_pkg;

  // Register word indices; the byte address is four times the index.
  localparam logic [7:0] TPG_IDX_CH0_CTRL   = 8'h20;
  localparam logic [7:0] TPG_IDX_CH1_CTRL   = 8'h22;
  localparam logic [7:0] TPG_IDX_CH0_PRE    = 8'h23;
  localparam logic [7:0] TPG_IDX_CH1_PRE    = 8'h24;
  localparam logic [7:0] TPG_IDX_STATUS     = 8'h25;

  // Control register field positions (same layout on both channels where shared).
  localparam int TPG_BIT_SOFT_TRIGGER = 7;
  localparam int TPG_BIT_RESTART_EN   = 6;
  localparam int TPG_BIT_STOP_EN      = 5;
  localparam int TPG_BIT_PRESC_HI     = 4;
  localparam int TPG_BIT_PRESC_LO     = 2;
  localparam int TPG_BIT_CMP1_EN      = 1;
  localparam int TPG_BIT_CMP0_EN      = 0;
  localparam int TPG_BIT_SWAP         = 0;

  // Status register field positions.
  localparam int TPG_ST_CNT0_LO = 0;
  localparam int TPG_ST_CNT1_LO = 8;
  localparam int TPG_ST_RUN0    = 16;
  localparam int TPG_ST_RUN1    = 17;
  localparam int TPG_ST_CMP0    = 18;
  localparam int TPG_ST_CMP1    = 19;
  localparam int TPG_ST_IRQA    = 20;
  localparam int TPG_ST_IRQB    = 21;

  // Values after reset, and the terminal count of the counter.
  localparam logic [7:0] TPG_CTRL_RESET = 8'h00;
  localparam logic [7:0] TPG_PRE_RESET  = 8'h00;
  localparam logic [7:0] TPG_COUNT_MAX  = 8'hff;

  // Index of each synchronised trigger input.
  localparam int TPG_IN_CMP0 = 0;
  localparam int TPG_IN_CMP1 = 1;
  localparam int TPG_IN_IRQA = 2;
  localparam int TPG_IN_IRQB = 3;

  // Counting state of one channel.
  typedef struct packed {
    logic       running;
    logic [7:0] count;
    logic [6:0] presc;
  } tpg_chan_t;

  // State of the block but the reset synchroniser and hresp flops, registered in one process.
  typedef struct packed {
    tpg_chan_t   ch0;
    tpg_chan_t   ch1;
    logic [6:0]  ctl0;
    logic [6:0]  ctl1;
    logic [7:0]  pre0;
    logic [7:0]  pre1;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  prev;
    logic        dp_write;
    logic        dp_hit;
    logic [7:0]  dp_idx;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        out0;
    logic        out1;
    logic        pa0_o;
    logic        pa0_oe;
    logic        pc2_oe;
    logic        pc2_pu;
    logic        pc3_oe;
    logic        pc3_pu;
    logic        cmp0_en;
    logic        cmp1_en;
  } tpg_state_t;

endpackage : tpg_pkg

// file: tpg_top.sv
// Two-channel triggered single-pulse generator with AHB-Lite register slave.
//
// Functional notes
// - Pulse spans up to 256 prescaled periods
// - Two independent 8-bit channels with registers
// - Falling trigger edge emits one pulse
// - Output polarity fixed by build parameter
// - Preload zero gives 256-period pulse
// - Counter starts at preload, counts up
// - Overflow reloads counter and stops channel
// - Overflow clears the software trigger bit
// - Each preload sets its channel's width
// - Prescaler bits 4..2 divide by 1..128
// - Comparator 0 enable takes over pin
// - Comparator 1 enable takes over pin
// - Stop-trigger enable lets stop edge stop
// - Exchange bit picks channel 0 stop source
// - Channel 0 restart enable lets comparator 1 start
// - Trigger bit write 1 starts, 0 stops
// - Starts while counting are ignored
// - Trigger bit reads pulse active status
// - Channel 1 pin option disables GPIO
// - Channel 0 control resets to zero
// - Exchange bit swaps stop, restart sources
//
// Register map; byte address is four times the word index.
//   Index 0x20: channel 0 control.
//   Index 0x22: channel 1 control.
//   Index 0x23: channel 0 preload.
//   Index 0x24: channel 1 preload.
//   Index 0x25: read-only status word.
// Other indices read as zero and ignore writes.
// So do addresses above 1 KB or not word aligned.
//
// Channel 0 control bits.
//   Bit 7 is the soft trigger, read as running.
//   Bit 6 lets comparator 1 falling start it.
//   Bit 5 lets the stop source falling stop it.
//   Bits 4:2 divide by two to the code.
//   Bit 1 enables comparator 1 and its pin.
//   Bit 0 enables comparator 0 and its pin.
//
// Channel 1 control bits.
//   Bit 7 is the soft trigger, read as running.
//   Bit 6 lets the restart source start it.
//   Bit 5 lets interrupt pin a stop it.
//   Bits 4:2 select the prescaler.
//   Bit 1 is absent and reads as zero.
//   Bit 0 swaps the stop and restart sources.
//
// Status word.
//   Bits 15:0 hold the two live counts.
//   Bits 17:16 hold the running flags.
//   Bits 19:18 hold the comparator levels.
//   Bits 21:20 are high while a pin is low.
//
// Bus timing.
//   The slave never stalls and answers OKAY.
//   Writes land at the end of the data phase.
//   Reads load at the address-phase edge.
//   A read after a write sees the new value.
//
// Trigger timing.
//   Inputs pass two flops and an edge flop.
//   A pin edge acts two to three cycles on.
//   Pulses under one clock may be missed.
//
// Pulse width.
//   A start loads the counter from preload.
//   Width is 256 minus preload periods.
//   A preload of zero gives 256 periods.
//   The prescaler restarts at each start.
//   A preload written mid-pulse waits.
//
// Hazard: swapping sources with triggers
// enabled can fake an edge, so software
// clears both enables first.
`timescale 1ns/10ps

module tpg_top
  import tpg_pkg::*;
#(
  parameter bit CH0_ACTIVE_HIGH = 1'b1,
  parameter bit CH1_ACTIVE_HIGH = 1'b1,
  parameter bit CH1_ON_PIN      = 1'b1
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Trigger inputs from comparators and interrupt pins (asynchronous).
  input  wire logic        comparator0_out,
  input  wire logic        comparator1_out,
  input  wire logic        ext_irq_pin_a_n,
  input  wire logic        ext_irq_pin_b_n,
  // Ordinary port logic requests, same clock.
  input  wire logic        gpio_pa0_o,
  input  wire logic        gpio_pa0_oe,
  input  wire logic        gpio_pc2_oe,
  input  wire logic        gpio_pc2_pu,
  input  wire logic        gpio_pc3_oe,
  input  wire logic        gpio_pc3_pu,
  // Pulse outputs and pin controls.
  output logic             pulse_ch0_out,
  output logic             pulse_ch1_out,
  output logic             port_a_pin0_o,
  output logic             port_a_pin0_oe,
  output logic             port_c_pin2_oe,
  output logic             port_c_pin2_pu,
  output logic             port_c_pin3_oe,
  output logic             port_c_pin3_pu,
  output logic             comparator0_enable,
  output logic             comparator1_enable
);

  // Prescaler terminal mask: divide by 2**sel needs sel low bits all ones.
  function automatic logic [6:0] presc_mask(input logic [2:0] sel);
    logic [7:0] m;
    m = (8'h01 << sel) - 8'h01;
    return m[6:0];
  endfunction : presc_mask

  // Both channels share this engine so they cannot drift apart.
  // While stopped, a start beats a stop in the same cycle.
  // While running, a stop wins and starts are ignored,
  // so a second trigger cannot stretch the pulse.
  // A stop reloads the counter, as an overflow does,
  // so the status shows where the next pulse begins.
  // The counter moves only at the prescaler terminal mask.
  // One clock of channel counting; starts are only honoured while stopped.
  function automatic tpg_chan_t chan_step(input tpg_chan_t  c,
                                          input logic [7:0] pre,
                                          input logic [2:0] sel,
                                          input logic       start,
                                          input logic       stop);
    tpg_chan_t n;
    n = c;
    if (!c.running) begin
      if (start) begin
        n.running = 1'b1;
        n.count   = pre;
        n.presc   = 7'h00;
      end
    end else if (stop) begin
      n.running = 1'b0;
      n.count   = pre;
      n.presc   = 7'h00;
    end else if (c.presc == presc_mask(sel)) begin
      n.presc = 7'h00;
      if (c.count == TPG_COUNT_MAX) begin
        n.count   = pre;
        n.running = 1'b0;
      end else begin
        n.count = c.count + 8'h01;
      end
    end else begin
      n.presc = c.presc + 7'h01;
    end
    return n;
  endfunction : chan_step

  // The pin may rise at any time against the clock.
  // Releasing flops directly could free some a cycle early.
  // The copy frees the block on one clean edge,
  // at the price of two cycles of reset latency.
  // Reset release synchroniser; every other flop uses its output.
  logic rst_meta;
  logic rst_n_sync;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta   <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_n_sync <= rst_meta;
    end
  end

  // All block state but the reset synchroniser and hresp flops is one struct: one process builds it,
  // one process registers it.
  tpg_state_t st_reg;
  tpg_state_t st_next;

  logic [3:0]  fall;
  logic        stop_source_fall;
  logic        restart_source_fall;
  logic        wr_ctl0;
  logic        wr_ctl1;
  logic [7:0]  wdata;
  logic        start0;
  logic        stop0;
  logic        start1;
  logic        stop1;
  logic        addr_ok;
  logic [31:0] rd_word;

  // Next-state logic for the whole block.
  always_comb begin
    st_next = st_reg;

    // Trigger inputs pass two flops, then an edge against the previous sample.
    st_next.sync1 = {ext_irq_pin_b_n, ext_irq_pin_a_n, comparator1_out, comparator0_out};
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2;
    fall          = st_reg.prev & ~st_reg.sync2;

    // Source exchange; swapping with triggers enabled may give a false edge.
    if (st_reg.ctl1[TPG_BIT_SWAP]) begin
      stop_source_fall    = fall[TPG_IN_CMP0];
      restart_source_fall = fall[TPG_IN_IRQB];
    end else begin
      stop_source_fall    = fall[TPG_IN_IRQB];
      restart_source_fall = fall[TPG_IN_CMP0];
    end

    // Writes use the registered data-phase flags, since
    // hwdata is valid only one cycle after the address.
    // Bit 1 of channel 1 is forced to zero for readback.
    // Register writes land in the data phase.
    wdata   = hwdata[7:0];
    wr_ctl0 = st_reg.dp_write && st_reg.dp_hit && (st_reg.dp_idx == TPG_IDX_CH0_CTRL);
    wr_ctl1 = st_reg.dp_write && st_reg.dp_hit && (st_reg.dp_idx == TPG_IDX_CH1_CTRL);
    if (wr_ctl0) begin
      st_next.ctl0 = wdata[6:0];
    end
    if (wr_ctl1) begin
      st_next.ctl1 = {wdata[6:2], 1'b0, wdata[TPG_BIT_SWAP]};
    end
    if (st_reg.dp_write && st_reg.dp_hit && (st_reg.dp_idx == TPG_IDX_CH0_PRE)) begin
      st_next.pre0 = wdata;
    end
    if (st_reg.dp_write && st_reg.dp_hit && (st_reg.dp_idx == TPG_IDX_CH1_PRE)) begin
      st_next.pre1 = wdata;
    end

    // Every control write is a start or a stop by bit 7,
    // so software changing only the prescaler must
    // write bit 7 with the running state.
    // Start and stop requests; a start while running simply finds no effect.
    start0 = (wr_ctl0 && wdata[TPG_BIT_SOFT_TRIGGER])
           || (st_reg.ctl0[TPG_BIT_RESTART_EN] && fall[TPG_IN_CMP1]);
    stop0  = (wr_ctl0 && !wdata[TPG_BIT_SOFT_TRIGGER])
           || (st_reg.ctl0[TPG_BIT_STOP_EN] && stop_source_fall);
    start1 = (wr_ctl1 && wdata[TPG_BIT_SOFT_TRIGGER])
           || (st_reg.ctl1[TPG_BIT_RESTART_EN] && restart_source_fall);
    stop1  = (wr_ctl1 && !wdata[TPG_BIT_SOFT_TRIGGER])
           || (st_reg.ctl1[TPG_BIT_STOP_EN] && fall[TPG_IN_IRQA]);

    // Both channels share the same counting engine.
    st_next.ch0 = chan_step(st_reg.ch0, st_reg.pre0,
                            st_reg.ctl0[TPG_BIT_PRESC_HI:TPG_BIT_PRESC_LO], start0, stop0);
    st_next.ch1 = chan_step(st_reg.ch1, st_reg.pre1,
                            st_reg.ctl1[TPG_BIT_PRESC_HI:TPG_BIT_PRESC_LO], start1, stop1);

    // Outputs follow the running flag at the built-in polarity.
    st_next.out0 = st_next.ch0.running ~^ CH0_ACTIVE_HIGH;
    st_next.out1 = st_next.ch1.running ~^ CH1_ACTIVE_HIGH;

    // An enabled comparator owns its pin: the port logic
    // loses driver and pull-up but may still read it.
    // The channel 1 pin option is fixed at build time.
    // Pin takeover by the comparators and the channel 1 pin option.
    st_next.cmp0_en = st_next.ctl0[TPG_BIT_CMP0_EN];
    st_next.cmp1_en = st_next.ctl0[TPG_BIT_CMP1_EN];
    st_next.pc2_oe  = gpio_pc2_oe & ~st_next.ctl0[TPG_BIT_CMP0_EN];
    st_next.pc2_pu  = gpio_pc2_pu & ~st_next.ctl0[TPG_BIT_CMP0_EN];
    st_next.pc3_oe  = gpio_pc3_oe & ~st_next.ctl0[TPG_BIT_CMP1_EN];
    st_next.pc3_pu  = gpio_pc3_pu & ~st_next.ctl0[TPG_BIT_CMP1_EN];
    if (CH1_ON_PIN) begin
      st_next.pa0_o  = st_next.out1;
      st_next.pa0_oe = 1'b1;
    end else begin
      st_next.pa0_o  = gpio_pa0_o;
      st_next.pa0_oe = gpio_pa0_oe;
    end

    // Only flags and the word index are kept, so the
    // write decode needs no copy of the full address.
    // Address phase capture; the slave never inserts wait states.
    addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
    st_next.hreadyout = 1'b1;
    st_next.dp_write  = 1'b0;
    if (hsel && htrans[1] && hready) begin
      st_next.dp_write = hwrite;
      st_next.dp_hit   = addr_ok;
      st_next.dp_idx   = haddr[9:2];
    end

    // Status inputs come from the synchroniser,
    // never from the raw pins.
    // Read data taken from next-state values so a write just before is seen.
    unique case (haddr[9:2])
      TPG_IDX_CH0_CTRL: rd_word = {24'h000000, st_next.ch0.running,
                                   st_next.ctl0};
      TPG_IDX_CH1_CTRL: rd_word = {24'h000000, st_next.ch1.running, st_next.ctl1};
      TPG_IDX_CH0_PRE:  rd_word = {24'h000000, st_next.pre0};
      TPG_IDX_CH1_PRE:  rd_word = {24'h000000, st_next.pre1};
      TPG_IDX_STATUS:   rd_word = {10'h000, ~st_reg.sync2[TPG_IN_IRQB],
                                   ~st_reg.sync2[TPG_IN_IRQA],
                                   st_reg.sync2[TPG_IN_CMP1], st_reg.sync2[TPG_IN_CMP0],
                                   st_next.ch1.running, st_next.ch0.running,
                                   st_next.ch1.count, st_next.ch0.count};
      default:          rd_word = 32'h00000000;
    endcase
    if (hsel && htrans[1] && hready && !hwrite && addr_ok) begin
      st_next.hrdata = rd_word;
    end else if (hsel && htrans[1] && hready) begin
      st_next.hrdata = 32'h00000000;
    end
  end

  // State register; reset clears control bits and parks outputs inactive.
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      st_reg           <= '0;
      st_reg.hreadyout <= 1'b1;
      st_reg.sync1     <= 4'hf;
      st_reg.sync2     <= 4'hf;
      st_reg.prev      <= 4'hf;
      st_reg.out0      <= ~CH0_ACTIVE_HIGH;
      st_reg.out1      <= ~CH1_ACTIVE_HIGH;
      st_reg.pa0_o     <= CH1_ON_PIN & ~CH1_ACTIVE_HIGH;
      st_reg.pa0_oe    <= CH1_ON_PIN;
    end else begin
      st_reg <= st_next;
    end
  end

  // Hresp is constant OKAY; a flop keeps every output registered.
  logic hresp_reg;

  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      hresp_reg <= 1'b0;
    end else begin
      hresp_reg <= 1'b0;
    end
  end

  // Pins never glitch while next-state logic settles;
  // the cost is one cycle from a write to the pins.
  // Outputs straight from the state flops.
  assign hrdata             = st_reg.hrdata;
  assign hreadyout          = st_reg.hreadyout;
  assign hresp              = hresp_reg;
  assign pulse_ch0_out      = st_reg.out0;
  assign pulse_ch1_out      = st_reg.out1;
  assign port_a_pin0_o      = st_reg.pa0_o;
  assign port_a_pin0_oe     = st_reg.pa0_oe;
  assign port_c_pin2_oe     = st_reg.pc2_oe;
  assign port_c_pin2_pu     = st_reg.pc2_pu;
  assign port_c_pin3_oe     = st_reg.pc3_oe;
  assign port_c_pin3_pu     = st_reg.pc3_pu;
  assign comparator0_enable = st_reg.cmp0_en;
  assign comparator1_enable = st_reg.cmp1_en;

endmodule : tpg_top

// file: tpg_props.sv
// Checker with concurrent assertions on the pulse generator top-level ports.
`timescale 1ns/10ps
module tpg_props
  import tpg_pkg::*;
#(
  parameter bit CH0_ACTIVE_HIGH = 1'b1,
  parameter bit CH1_ON_PIN      = 1'b1
) (
  // Clock and reset.
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // Register bus.
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Outputs and pin controls.
  input wire logic        pulse_ch0_out,
  input wire logic        pulse_ch1_out,
  input wire logic        port_a_pin0_o,
  input wire logic        port_a_pin0_oe,
  input wire logic        port_c_pin2_oe,
  input wire logic        port_c_pin2_pu,
  input wire logic        port_c_pin3_oe,
  input wire logic        port_c_pin3_pu,
  input wire logic        comparator0_enable,
  input wire logic        comparator1_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  logic        act0;
  logic [15:0] run_len;
  assign act0 = (pulse_ch0_out == CH0_ACTIVE_HIGH);

  // Length of the current channel 0 pulse; a stuck counter shows up as an endless pulse.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) run_len <= 16'h0;
    else run_len <= act0 ? run_len + 16'h1 : 16'h0;
  end

  // Accepted address phase of a write to the channel 0 control register.
  sequence wr_ctl0;
    hsel && htrans == 2'b10 && hwrite && hready && haddr == {22'h0, TPG_IDX_CH0_CTRL, 2'b00};
  endsequence

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("Slave stalled or answered with an error.");
  chk_soft_start: assert property (wr_ctl0 ##1 (hwdata[7] && !act0) |=> act0)
    else $error("Trigger bit write did not start the pulse.");
  chk_soft_stop: assert property (wr_ctl0 ##1 !hwdata[7] |=> !act0)
    else $error("Trigger bit clear did not end the pulse.");
  chk_width_max: assert property (run_len <= 16'd32769)
    else $error("Pulse longer than 256 slowest periods.");
  chk_cmp0_pins: assert property ((comparator0_enable && $past(comparator0_enable))
    |-> !port_c_pin2_oe && !port_c_pin2_pu)
    else $error("Comparator 0 pin still driven or pulled up.");
  chk_cmp1_pins: assert property ((comparator1_enable && $past(comparator1_enable))
    |-> !port_c_pin3_oe && !port_c_pin3_pu)
    else $error("Comparator 1 pin still driven or pulled up.");
  chk_ch1_pin: assert property (CH1_ON_PIN |-> port_a_pin0_oe && port_a_pin0_o == pulse_ch1_out)
    else $error("Shared pin does not carry the channel 1 pulse.");
  chk_cmp_enables: assert property (wr_ctl0 ##1 1'b1 |-> ##2 (comparator0_enable ==
    $past(hwdata[0], 2) && comparator1_enable == $past(hwdata[1], 2)))
    else $error("Comparator enables do not follow the control write.");
endmodule : tpg_props

bind tpg_top tpg_props #(.CH0_ACTIVE_HIGH(CH0_ACTIVE_HIGH), .CH1_ON_PIN(CH1_ON_PIN)) u_props (
  .ref_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
  .pulse_ch0_out, .pulse_ch1_out, .port_a_pin0_o, .port_a_pin0_oe, .port_c_pin2_oe,
  .port_c_pin2_pu, .port_c_pin3_oe, .port_c_pin3_pu, .comparator0_enable, .comparator1_enable);

// file: tpg_trig_model.sv
// Behavioural model of the two comparators and the two external trigger pins.
`timescale 1ns/10ps
module tpg_trig_model (
  // Clock used only to time the pulses.
  input wire logic ref_clk,
  // Trigger lines toward the generator.
  output logic     comparator0_out,
  output logic     comparator1_out,
  output logic     ext_irq_pin_a_n,
  output logic     ext_irq_pin_b_n
);
  // Comparators rest high and the interrupt pins have pull-ups, so all lines idle high.
  initial {comparator0_out, comparator1_out, ext_irq_pin_a_n, ext_irq_pin_b_n} = 4'hf;

  task automatic drive(input int idx, input logic v);
    case (idx)
      0: comparator0_out = v;
      1: comparator1_out = v;
      2: ext_irq_pin_a_n = v;
      default: ext_irq_pin_b_n = v;
    endcase
  endtask : drive

  // Falls off the clock edge so the synchronisers see a truly asynchronous edge.
  task automatic fall(input int idx, input int low_cycles);
    @(posedge ref_clk);
    #17 drive(idx, 1'b0);
    fork
      begin
        repeat (low_cycles) @(posedge ref_clk);
        #9 drive(idx, 1'b1);
      end
    join_none
  endtask : fall
endmodule : tpg_trig_model

// file: tb.sv
// Self-checking testbench of the triggered pulse generator.
`timescale 1ns/10ps
module tb;
  import tpg_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0]  htrans = 2'b00;
  logic [5:0]  gp = 6'h3f;
  logic hreadyout, hresp, pulse_ch0_out, pulse_ch1_out, port_a_pin0_o, port_a_pin0_oe;
  logic port_c_pin2_oe, port_c_pin2_pu, port_c_pin3_oe, port_c_pin3_pu;
  logic comparator0_enable, comparator1_enable, comparator0_out, comparator1_out;
  logic ext_irq_pin_a_n, ext_irq_pin_b_n;
  int   err_count = 0, total_checks = 0, cyc = 0, w;

  always #25 ref_clk = ~ref_clk;

  tpg_top i_tpg_top (.ref_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .comparator0_out,
    .comparator1_out, .ext_irq_pin_a_n, .ext_irq_pin_b_n, .gpio_pa0_o(gp[0]),
    .gpio_pa0_oe(gp[1]), .gpio_pc2_oe(gp[2]), .gpio_pc2_pu(gp[3]), .gpio_pc3_oe(gp[4]),
    .gpio_pc3_pu(gp[5]), .pulse_ch0_out, .pulse_ch1_out, .port_a_pin0_o, .port_a_pin0_oe,
    .port_c_pin2_oe, .port_c_pin2_pu, .port_c_pin3_oe, .port_c_pin3_pu,
    .comparator0_enable, .comparator1_enable);

  tpg_trig_model u_trig (.ref_clk, .comparator0_out, .comparator1_out, .ext_irq_pin_a_n,
    .ext_irq_pin_b_n);

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // One single AHB-Lite transfer; hrdata is stable at the closing edge, so no race there.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, wr, 22'h0, idx, 2'b00};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, 24'h0, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  function automatic logic act(input bit ch);
    return ch ? pulse_ch1_out === 1'b1 : pulse_ch0_out === 1'b1;
  endfunction : act

  // Counts active cycles on falling edges, after a bounded wait for the pulse to begin.
  task automatic width(input bit ch, output int n);
    int k;
    k = 0;
    n = 0;
    @(negedge ref_clk);
    while (!act(ch) && k < 12) begin @(negedge ref_clk); k++; end
    while (act(ch) && n < 40000) begin n++; @(negedge ref_clk); end
  endtask : width

  task automatic t_reset;
    bus(0, TPG_IDX_CH0_CTRL, 8'h0); check(q, 32'h0, "control after reset");
    bus(0, 8'hff, 8'h0); check(q, 32'h0, "unmapped read");
    check(32'(hresp), 0, "response okay");
  endtask : t_reset

  task automatic t_width;
    for (int p = 0; p < 8; p++) begin
      bus(1, TPG_IDX_CH0_PRE, 8'hfc);
      bus(1, TPG_IDX_CH0_CTRL, {3'b100, 3'(p), 2'b00});
      width(0, w);
      check(32'(w >= (4 << p) - (1 << p) && w <= (4 << p) + 1), 1, "prescaled width");
      bus(0, TPG_IDX_CH0_CTRL, 8'h0); check(32'(q[7]), 0, "trigger bit after wrap");
    end
    bus(1, TPG_IDX_CH0_PRE, 8'h00);
    bus(1, TPG_IDX_CH0_CTRL, 8'h80); width(0, w); check(w, 256, "zero preload width");
  endtask : t_width

  // A second start while counting must not lengthen the pulse.
  task automatic t_retrig;
    int t0;
    bus(1, TPG_IDX_CH0_CTRL, 8'h80);
    t0 = cyc;
    repeat (90) @(posedge ref_clk);
    bus(0, TPG_IDX_CH0_CTRL, 8'h0); check(32'(q[7]), 1, "trigger bit while active");
    bus(1, TPG_IDX_CH0_CTRL, 8'h80);
    width(0, w); check(32'(cyc - t0 >= 250 && cyc - t0 <= 262), 1, "retrigger ignored");
  endtask : t_retrig

  // Stop by software, by the stop source, and with the sources exchanged.
  task automatic t_stop;
    bus(1, TPG_IDX_CH0_CTRL, 8'h9c); u_trig.fall(3, 2); repeat (8) @(negedge ref_clk);
    check(32'(act(0)), 1, "stop edge with stop disabled");
    bus(1, TPG_IDX_CH0_CTRL, 8'h1c); @(negedge ref_clk); check(32'(act(0)), 0, "soft stop");
    bus(1, TPG_IDX_CH0_CTRL, 8'hbc); u_trig.fall(3, 2); repeat (8) @(negedge ref_clk);
    check(32'(act(0)), 0, "stop by pin b");
    bus(1, TPG_IDX_CH1_CTRL, 8'h01);
    bus(1, TPG_IDX_CH0_CTRL, 8'hbc); u_trig.fall(3, 2); repeat (8) @(negedge ref_clk);
    check(32'(act(0)), 1, "pin b ignored when swapped");
    u_trig.fall(0, 2); repeat (8) @(negedge ref_clk);
    check(32'(act(0)), 0, "stop by comparator 0 when swapped");
    bus(1, TPG_IDX_CH1_CTRL, 8'h00);
  endtask : t_stop

  task automatic t_restart;
    bus(1, TPG_IDX_CH0_PRE, 8'hf0);
    bus(1, TPG_IDX_CH0_CTRL, 8'h40); u_trig.fall(1, 2); width(0, w);
    check(w, 16, "comparator 1 start width");
    bus(1, TPG_IDX_CH0_CTRL, 8'h00); u_trig.fall(1, 2); width(0, w);
    check(w, 0, "start edge with restart disabled");
  endtask : t_restart

  task automatic t_ch1_pins;
    bus(1, TPG_IDX_CH1_PRE, 8'hf8);
    bus(1, TPG_IDX_CH1_CTRL, 8'h80); width(1, w); check(w, 8, "channel 1 width");
    bus(1, TPG_IDX_CH1_CTRL, 8'hbc); u_trig.fall(2, 2); repeat (8) @(negedge ref_clk);
    check(32'(act(1)), 0, "channel 1 stop by pin a");
    bus(1, TPG_IDX_CH1_CTRL, 8'h40); u_trig.fall(0, 2); width(1, w);
    check(w, 8, "channel 1 restart by comparator 0");
    bus(0, TPG_IDX_STATUS, 8'h0); check(q, 32'h000cf8f0, "idle status");
    bus(1, TPG_IDX_CH1_CTRL, 8'h00);
    bus(1, TPG_IDX_CH0_CTRL, 8'h03); repeat (3) @(negedge ref_clk);
    check(32'({port_c_pin2_oe, port_c_pin3_oe}), 0, "pins taken by comparators");
    check(32'({comparator1_enable, comparator0_enable, port_c_pin2_pu, port_c_pin3_pu}),
      12, "comparator enables");
    bus(1, TPG_IDX_CH0_CTRL, 8'h00); repeat (3) @(negedge ref_clk);
    check(32'({port_c_pin2_oe, port_c_pin3_pu}), 3, "pins back to port logic");
  endtask : t_ch1_pins

  task automatic stop_test;
    $display("Checks made: %0d, mismatches: %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // Cycle ceiling well above the few thousand cycles the scenarios need.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_width();
    t_retrig();
    t_stop();
    t_restart();
    t_ch1_pins();
    stop_test();
  end
endmodule : tb
